// >>> rtl/spo_pkg.sv
// Package for the serial pin override port: register map and carriers
package spo_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [3:0] PORT_PIN_LEVELS_OFF = 4'h0;
  localparam logic [3:0] PORT_OUTPUT_LATCH_OFF = 4'h4;
  localparam logic [3:0] PORT_DIRECTION_OFF = 4'h8;
  localparam logic [3:0] SLEW_RATE_CONTROL_OFF = 4'hC;

  // Reset values
  localparam logic [7:0] PORT_DIRECTION_RST = 8'hFF;
  localparam logic [7:0] PORT_OUTPUT_LATCH_RST = 8'h00;
  localparam logic [7:0] SLEW_RATE_CONTROL_RST = 8'h00;
  // Implemented slew bits: low five
  localparam logic [7:0] SLEW_RATE_MASK = 8'h1F;

  // Pin positions of the shared pins
  localparam int CAPTURE_PIN = 1;
  localparam int SPI_CLOCK_PIN = 3;
  localparam int SPI_IN_PIN = 4;
  localparam int SPI_OUT_PIN = 5;
  localparam int TX_PIN = 6;
  localparam int RX_PIN = 7;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Mode of the synchronous serial peripheral
  typedef enum logic [1:0] {SSP_OFF, SSP_SPI, SSP_I2C} spo_ssp_mode_type;

  // Controls from the synchronous serial peripheral
  typedef struct packed {
    spo_ssp_mode_type mode;
    logic spi_master;
    logic spi_clock_out;
    logic spi_serial_out;
    logic i2c_smbus_levels;
    logic i2c_clock_low;
    logic i2c_data_low;
  } spo_ssp_ctl_type;

  // Controls from the serial transceiver
  typedef struct packed {
    logic enable;
    logic sync_mode;
    logic sync_master;
    logic sync_transmitting;
    logic tx_data;
    logic sync_clock_out;
    logic sync_data_out;
  } spo_xcvr_ctl_type;

  // Inputs returned to the peripherals
  typedef struct packed {
    logic spi_clock_in;
    logic spi_serial_in;
    logic i2c_clock_in;
    logic i2c_data_in;
    logic rx_data;
    logic transceiver_sync_clock;
    logic transceiver_sync_data;
    logic capture_in;
    logic alternate_capture_out;
    logic alternate_capture_oe;
  } spo_periph_in_type;

endpackage : spo_pkg

// >>> rtl/spo_port.sv
// Pin multiplexer and register file of the shared serial port
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module spo_port
  import spo_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite write channels
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral side
  input wire spo_pkg::spo_ssp_ctl_type ssp_ctl,
  input wire spo_pkg::spo_xcvr_ctl_type xcvr_ctl,
  input wire logic capture_compare_two_out,
  input wire logic capture_compare_two_drive,
  input wire logic capture_two_pin_select,
  input wire logic alternate_capture_pin_in,
  output spo_pkg::spo_periph_in_type periph_in,
  // Pads
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_smbus_levels
);
  import spo_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers and sampling
  logic [7:0] port_output_latch;
  logic [7:0] port_direction;
  logic [7:0] slew_rate_control;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] next_out;
  logic [7:0] next_oe;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic spi_on;
  logic i2c_on;
  logic cap_here;

  assign spi_on = (ssp_ctl.mode == SSP_SPI);
  assign i2c_on = (ssp_ctl.mode == SSP_I2C);
  assign cap_here = capture_two_pin_select;

  // Two-stage pin synchroniser
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Address and data capture, either order
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Register writes; pin register write lands in the latch
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      port_output_latch <= PORT_OUTPUT_LATCH_RST;
      port_direction <= PORT_DIRECTION_RST;
      slew_rate_control <= SLEW_RATE_CONTROL_RST;
    end
    else if (do_write && w_strb[0])
    begin
      case (aw_addr)
        PORT_PIN_LEVELS_OFF, PORT_OUTPUT_LATCH_OFF:
          port_output_latch <= w_data[7:0];
        PORT_DIRECTION_OFF:
          port_direction <= w_data[7:0];
        SLEW_RATE_CONTROL_OFF:
          slew_rate_control <= w_data[7:0] & SLEW_RATE_MASK;
        default:
          port_output_latch <= port_output_latch;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          PORT_PIN_LEVELS_OFF:
            s_axi_rdata <= {24'h000000, pin_sync};
          PORT_OUTPUT_LATCH_OFF:
            s_axi_rdata <= {24'h000000, port_output_latch};
          PORT_DIRECTION_OFF:
            s_axi_rdata <= {24'h000000, port_direction};
          SLEW_RATE_CONTROL_OFF:
            s_axi_rdata <= {24'h000000, slew_rate_control};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin driver selection
  always_comb
  begin
    // Plain port behaviour for every pin
    next_out = port_output_latch;
    next_oe = ~port_direction;
    // Capture/compare output on pin 1 when selected
    if (cap_here && capture_compare_two_drive && !port_direction[CAPTURE_PIN])
      next_out[CAPTURE_PIN] = capture_compare_two_out;
    // SPI clock out as master
    if (spi_on && ssp_ctl.spi_master && !port_direction[SPI_CLOCK_PIN])
      next_out[SPI_CLOCK_PIN] = ssp_ctl.spi_clock_out;
    // SPI data out
    if (spi_on && !port_direction[SPI_OUT_PIN])
      next_out[SPI_OUT_PIN] = ssp_ctl.spi_serial_out;
    // I2C open-drain pulls own clock and data pins
    if (i2c_on)
    begin
      next_out[SPI_CLOCK_PIN] = 1'b0;
      next_oe[SPI_CLOCK_PIN] = ssp_ctl.i2c_clock_low;
      next_out[SPI_IN_PIN] = 1'b0;
      next_oe[SPI_IN_PIN] = ssp_ctl.i2c_data_low;
    end
    // Transceiver pins
    if (xcvr_ctl.enable)
    begin
      if (!xcvr_ctl.sync_mode)
        next_out[TX_PIN] = xcvr_ctl.tx_data;
      else
      begin
        // Clock direction set by master or slave role
        next_out[TX_PIN] = xcvr_ctl.sync_clock_out;
        next_oe[TX_PIN] = xcvr_ctl.sync_master;
        // Data pin driven only while sending
        next_out[RX_PIN] = xcvr_ctl.sync_data_out;
        next_oe[RX_PIN] = xcvr_ctl.sync_transmitting;
      end
    end
  end

  // Registered pad drive
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      pin_smbus_levels <= 8'h00;
    end
    else
    begin
      pin_out <= next_out;
      pin_oe <= next_oe;
      // Input level type of the I2C pins
      pin_smbus_levels <= 8'h00;
      pin_smbus_levels[SPI_CLOCK_PIN] <= i2c_on && ssp_ctl.i2c_smbus_levels;
      pin_smbus_levels[SPI_IN_PIN] <= i2c_on && ssp_ctl.i2c_smbus_levels;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Peripheral inputs; SPI gated by function and direction, I2C by function, receive by direction
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      periph_in <= '0;
    else
    begin
      periph_in.spi_clock_in <= spi_on && port_direction[SPI_CLOCK_PIN]
                                && pin_sync[SPI_CLOCK_PIN];
      periph_in.spi_serial_in <= spi_on && port_direction[SPI_IN_PIN]
                                 && pin_sync[SPI_IN_PIN];
      periph_in.i2c_clock_in <= i2c_on && pin_sync[SPI_CLOCK_PIN];
      periph_in.i2c_data_in <= i2c_on && pin_sync[SPI_IN_PIN];
      periph_in.rx_data <= port_direction[RX_PIN]
                           && pin_sync[RX_PIN];
      periph_in.transceiver_sync_clock <= pin_sync[TX_PIN];
      periph_in.transceiver_sync_data <= pin_sync[RX_PIN];
      periph_in.capture_in <= cap_here ? pin_sync[CAPTURE_PIN]
                              : alternate_capture_pin_in;
      periph_in.alternate_capture_out <= capture_compare_two_out;
      periph_in.alternate_capture_oe <= !cap_here
                                        && capture_compare_two_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  direction_reset_a: assert property (@(posedge sys_clk)
    !rst_n |=> pin_oe == 8'h00 && port_direction == PORT_DIRECTION_RST)
    else $error("pins not inputs after reset");
  plain_drive_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) !i2c_on && !xcvr_ctl.enable && !spi_on |=>
    pin_oe == ~$past(port_direction))
    else $error("driver enable does not follow direction");
  spi_clock_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) spi_on && ssp_ctl.spi_master && !port_direction[3]
    |=> pin_out[3] == $past(ssp_ctl.spi_clock_out))
    else $error("spi clock not on pin");
  spi_out_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) spi_on && !port_direction[5] && !xcvr_ctl.enable
    |=> pin_out[5] == $past(ssp_ctl.spi_serial_out) && pin_oe[5])
    else $error("spi data out not on pin");
  i2c_data_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) i2c_on && ssp_ctl.i2c_data_low
    |=> pin_oe[4] && !pin_out[4])
    else $error("i2c data not pulled");
  tx_override_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) xcvr_ctl.enable && !xcvr_ctl.sync_mode
    |=> pin_out[6] == $past(xcvr_ctl.tx_data))
    else $error("transmit not on pin");
  sync_data_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) xcvr_ctl.enable && xcvr_ctl.sync_mode
    |=> pin_oe[7] == $past(xcvr_ctl.sync_transmitting))
    else $error("sync data drive wrong");
  slew_zero_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) slew_rate_control[7:5] == 3'h0)
    else $error("unimplemented slew bits set");
  upper_bits_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  capture_route_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) !cap_here ##1 !cap_here |->
    periph_in.capture_in == $past(alternate_capture_pin_in))
    else $error("capture not from alternate pin");

endmodule : spo_port

// >>> tb/spo_pad_model.sv
// Pad model for the shared port pins
`timescale 1ns/1ps
module spo_pad_model
(
  // Pad side of the block
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // Outside world
  input wire logic [7:0] ext_level,
  input wire logic [7:0] ext_drive,
  output logic [7:0] pin_in
);
  // Wire level: block first, then outside, a floating pin reads inverted
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_drive[i])
        pin_in[i] = ext_level[i];
      else
        pin_in[i] = ~pin_out[i];
    end
  end
endmodule : spo_pad_model

// >>> tb/serial_pin_override_port_test.sv
// Self-checking bench for the serial pin override port
`timescale 1ns/1ps
module serial_pin_override_port_test;
  import spo_pkg::*;
  localparam logic [3:0] DIR = PORT_DIRECTION_OFF;
  localparam logic [3:0] LAT = PORT_OUTPUT_LATCH_OFF;
  localparam logic [3:0] PIN = PORT_PIN_LEVELS_OFF;
  localparam logic [3:0] SLEW = SLEW_RATE_CONTROL_OFF;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  spo_ssp_ctl_type ssp_ctl = '0;
  spo_xcvr_ctl_type xcvr_ctl = '0;
  logic cc_out = 1'b0;
  logic cc_drive = 1'b0;
  logic cc_sel = 1'b1;
  logic alt_in = 1'b0;
  spo_periph_in_type periph_in;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] pin_smbus;
  logic [7:0] ext_level = 8'h3C;
  int mismatches = 0;
  int samples_checked = 0;
  ////////////////////////////////////////
  // Clock of 100 ns
  always #50 sys_clk = ~sys_clk;
  // Device and pads
  spo_port i_spo_port (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ssp_ctl, .xcvr_ctl, .capture_compare_two_out(cc_out),
    .capture_compare_two_drive(cc_drive), .capture_two_pin_select(cc_sel),
    .alternate_capture_pin_in(alt_in), .periph_in, .pin_in, .pin_out,
    .pin_oe, .pin_smbus_levels(pin_smbus));
  spo_pad_model i_spo_pad_model (.pin_out, .pin_oe, .ext_level,
    .ext_drive(8'hFF), .pin_in);
  ////////////////////////////////////////
  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // A bounded wait ran out
  task automatic hang();
    mismatches++;
    $display("mismatch at %0t: no bus answer", $time);
    give_verdict();
  endtask : hang
  // AXI4-Lite write, address and data offered together
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
    input logic [1:0] er);
    bit aw;
    bit w;
    int n;
    aw = 0;
    w = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge sys_clk);
      if (!aw && s_axi_awready === 1'b1)
      begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1)
      begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1)
        break;
    end
    if (n == 40)
      hang();
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr
  // AXI4-Lite read with data and response compare
  task automatic rd(input logic [3:0] a, input logic [7:0] ed,
    input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    if (n == 40)
      hang();
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, ed});
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd
  // Let pin and peripheral paths settle
  task automatic settle();
    repeat (6) @(posedge sys_clk);
  endtask : settle
  // End of one test
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask : done
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(DIR, 8'hFF, RESP_OKAY);
    rd(LAT, 8'h00, RESP_OKAY);
    rd(SLEW, 8'h00, RESP_OKAY);
    chk(32'(pin_oe), 32'h0);
    done("reset");
    wr(SLEW, 8'hFF, RESP_OKAY);
    rd(SLEW, 8'h1F, RESP_OKAY);
    wr(4'h2, 8'h55, RESP_SLVERR);
    rd(4'h1, 8'h00, RESP_SLVERR);
    done("registers");
    rd(PIN, 8'h3C, RESP_OKAY);
    wr(LAT, 8'hA5, RESP_OKAY);
    rd(LAT, 8'hA5, RESP_OKAY);
    rd(PIN, 8'h3C, RESP_OKAY);
    wr(DIR, 8'h00, RESP_OKAY);
    settle();
    chk(32'(pin_oe), 32'hFF);
    chk(32'(pin_out), 32'hA5);
    rd(PIN, 8'hA5, RESP_OKAY);
    done("port");
    wr(LAT, 8'h00, RESP_OKAY);
    wr(DIR, 8'hD7, RESP_OKAY);
    ssp_ctl <= '{mode: SSP_SPI, spi_master: 1'b1, spi_clock_out: 1'b1,
      spi_serial_out: 1'b1, default: 1'b0};
    settle();
    chk(32'(pin_out[3] & pin_oe[3]), 32'h1);
    chk(32'(pin_out[5] & pin_oe[5]), 32'h1);
    chk(32'(periph_in.spi_serial_in), 32'h1);
    rd(DIR, 8'hD7, RESP_OKAY);
    ssp_ctl.spi_master <= 1'b0;
    ext_level <= 8'hCB;
    wr(DIR, 8'hFF, RESP_OKAY);
    settle();
    chk(32'(pin_oe[3]), 32'h0);
    chk(32'(periph_in.spi_clock_in), 32'h1);
    chk(32'(periph_in.spi_serial_in), 32'h0);
    ssp_ctl <= '{mode: SSP_I2C, i2c_data_low: 1'b1, i2c_smbus_levels: 1'b1,
      default: 1'b0};
    ext_level <= 8'h0C;
    settle();
    chk(32'({pin_oe[4], pin_out[4]}), 32'h2);
    chk(32'(pin_smbus[4:3]), 32'h3);
    chk(32'(periph_in.i2c_clock_in), 32'h1);
    chk(32'(periph_in.i2c_data_in), 32'h0);
    ssp_ctl.i2c_smbus_levels <= 1'b0;
    settle();
    chk(32'(pin_smbus[4:3]), 32'h0);
    ssp_ctl <= '0;
    done("sync serial");
    wr(LAT, 8'h40, RESP_OKAY);
    wr(DIR, 8'hBF, RESP_OKAY);
    xcvr_ctl.enable <= 1'b1;
    ext_level <= 8'h80;
    settle();
    chk(32'({pin_oe[6], pin_out[6]}), 32'h2);
    chk(32'(periph_in.rx_data), 32'h1);
    done("async");
    wr(DIR, 8'hFF, RESP_OKAY);
    xcvr_ctl <= 7'h79;
    settle();
    chk(32'({pin_oe[7:6], pin_out[7:6]}), 32'hE);
    xcvr_ctl <= 7'h60;
    ext_level <= 8'h40;
    settle();
    chk(32'(pin_oe[7:6]), 32'h0);
    chk(32'(periph_in.transceiver_sync_clock), 32'h1);
    chk(32'(periph_in.transceiver_sync_data), 32'h0);
    xcvr_ctl <= '0;
    done("sync");
    wr(LAT, 8'h02, RESP_OKAY);
    wr(DIR, 8'hFD, RESP_OKAY);
    cc_drive <= 1'b1;
    settle();
    chk(32'(pin_out[1]), 32'h0);
    cc_sel <= 1'b0;
    alt_in <= 1'b1;
    settle();
    chk(32'(pin_out[1]), 32'h1);
    chk(32'(periph_in.alternate_capture_out), 32'h0);
    chk(32'(periph_in.alternate_capture_oe), 32'h1);
    chk(32'(periph_in.capture_in), 32'h1);
    done("capture");
    give_verdict();
  end
endmodule : serial_pin_override_port_test
